//--- include/ftsl_map.svh
// Register offsets, field positions, reset values and timing counts of the
// fan tachometer status and limit block. Assumes a 250 MHz APB clock.
// Summary of operation
// - Count-ready flag stays zero while the reading-mode select is zero.
// - In reading mode one, count-ready sets when a new period count latches.
// - Count-ready clears on a written one or when mode returns to zero; a written zero leaves it.
// - Count-ready flag with its enable drives the interrupt request.
// - Toggle flag sets on every input transition and clears on written one.
// - Toggle flag with its enable drives the interrupt request.
// - Status bit 1 reads the present input level and ignores writes.
// - Out-of-range sets when count exceeds upper or falls below lower bound.
// - Out-of-range clears only when software writes one to status bit 0.
// - Out-of-range flag with its enable drives the interrupt request.
// - Upper bound is a 16-bit read/write field resetting to FFFF.
// - A steady input level never sets the toggle flag.
// - Mode one counts 100 kHz ticks, latching and restarting per edge group.
// - Lower bound is 16 bits, resets to zero; zero disables the low check.
// - Control holds toggle enable 15, ready enable 14, range enable 0.
`ifndef FTSL_MAP_SVH
`define FTSL_MAP_SVH

// ==========================================================================
// Register offsets
`define FTSL_OFS_CTRL 8'h00
`define FTSL_OFS_FLAGS 8'h04
`define FTSL_OFS_UPPER 8'h08
`define FTSL_OFS_LOWER 8'h0C

// ==========================================================================
// Field positions
`define FTSL_CTRL_TOGGLE_IE 15
`define FTSL_CTRL_READY_IE 14
`define FTSL_CTRL_EDGES_HI 12
`define FTSL_CTRL_EDGES_LO 11
`define FTSL_CTRL_MODE 10
`define FTSL_CTRL_OOR_IE 0
`define FTSL_FLAG_READY 3
`define FTSL_FLAG_TOGGLE 2
`define FTSL_FLAG_LEVEL 1
`define FTSL_FLAG_OOR 0

// ==========================================================================
// Reset values
`define FTSL_UPPER_RST 16'hFFFF
`define FTSL_LOWER_RST 16'h0000

// ==========================================================================
// Timing
`define FTSL_CLK_PERIOD_NS 4
`define FTSL_REF_PERIOD_NS 10000
`define FTSL_REF_CYCLES (`FTSL_REF_PERIOD_NS / `FTSL_CLK_PERIOD_NS)

`endif

//--- include/ftsl_pkg.sv
// Types shared by the tachometer status block and its period counter.
// Assumes ftsl_map.svh supplies the numeric constants.
package ftsl_pkg;

    // ======================================================================
    // Bus response state
    typedef enum logic [0:0] {
        FTSL_BUS_IDLE = 1'b0,
        FTSL_BUS_RESP = 1'b1
    } ftsl_bus_st_t;

    // ======================================================================
    // Period counter state
    typedef struct packed {
        logic [11:0] div;
        logic [15:0] ref_cnt;
        logic [3:0] edges;
        logic [15:0] count;
        logic latch;
    } ftsl_per_t;

    // ======================================================================
    // Register block state
    typedef struct packed {
        ftsl_bus_st_t bus_st;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic level;
        logic level_prev;
        logic toggle_ie;
        logic ready_ie;
        logic oor_ie;
        logic mode;
        logic [1:0] edge_sel;
        logic [15:0] upper;
        logic [15:0] lower;
        logic ready_flag;
        logic toggle_flag;
        logic out_of_range_flag;
        logic irq;
    } ftsl_regs_t;

endpackage

//--- rtl/ftsl_period.sv
// Period counter of the tachometer block.
// Assumes the input level arrives already registered in the pclk domain.
`include "ftsl_map.svh"

module ftsl_period
    import ftsl_pkg::*;
#(
    parameter int REF_DIV = `FTSL_REF_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Input level and its previous sample
    input wire logic level,
    input wire logic level_prev,
    // Configuration
    input wire logic mode,
    input wire logic [1:0] edge_sel,
    // Result
    output logic [15:0] period_count,
    output logic latch_pulse
);

    ftsl_per_t q, d;
    logic [3:0] target;
    logic ref_tick;
    logic any_edge;
    logic rise_edge;

    // ======================================================================
    // Next state
    always_comb begin
        d = q;
        d.latch = 1'b0;
        unique case (edge_sel)
            2'h0: target = 4'h2;
            2'h1: target = 4'h3;
            2'h2: target = 4'h5;
            2'h3: target = 4'h9;
        endcase
        ref_tick = (q.div == 12'(REF_DIV - 1));
        any_edge = level ^ level_prev;
        rise_edge = level & ~level_prev;
        d.div = ref_tick ? 12'h000 : q.div + 12'h001;
        if (mode) begin
            // The closing edge of one group opens the next, so no edge is lost.
            if (ref_tick && q.ref_cnt != 16'hFFFF) begin
                d.ref_cnt = q.ref_cnt + 16'h0001;
            end
            if (any_edge) begin
                if (q.edges + 4'h1 >= target) begin
                    d.count = q.ref_cnt;
                    d.ref_cnt = 16'h0000;
                    d.edges = 4'h1;
                    d.latch = 1'b1;
                end else begin
                    d.edges = q.edges + 4'h1;
                end
            end
        end else begin
            d.ref_cnt = 16'h0000;
            d.edges = 4'h0;
            if (rise_edge) begin
                d.count = q.count + 16'h0001;
            end
        end
    end

    // ======================================================================
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign period_count = q.count;
    assign latch_pulse = q.latch;

endmodule

//--- rtl/ftsl_top.sv
// Status, bound and interrupt logic of the fan tachometer monitor.
// Assumes an APB master on pclk and a tachometer input synchronous to pclk.
//
// Chosen here: the APB slave port.
`include "ftsl_map.svh"

module ftsl_top
    import ftsl_pkg::*;
#(
    parameter int REF_DIV = `FTSL_REF_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Fan tachometer input
    input wire logic tach_in,
    // Interrupt request to the controller
    output logic irq
);

    ftsl_regs_t q, d;
    logic [15:0] period_count;
    logic latch_pulse;
    logic access;
    logic commit;
    logic wr;
    logic sel_ctrl;
    logic sel_flags;
    logic sel_upper;
    logic sel_lower;
    logic mapped;
    logic clr_ready;
    logic clr_toggle;
    logic clr_oor;
    logic set_ready;
    logic set_toggle;
    logic set_oor;
    logic above;
    logic below;
    logic [31:0] rd_ctrl;
    logic [31:0] rd_flags;
    logic [31:0] rd_upper;
    logic [31:0] rd_lower;
    logic [31:0] rd_mux;

    // ======================================================================
    // Period counter
    ftsl_period #(
        .REF_DIV(REF_DIV)
    ) u_period (
        .pclk(pclk),
        .presetn(presetn),
        .level(q.level),
        .level_prev(q.level_prev),
        .mode(q.mode),
        .edge_sel(q.edge_sel),
        .period_count(period_count),
        .latch_pulse(latch_pulse)
    );

    // ======================================================================
    // Address decode
    always_comb begin
        sel_ctrl = (paddr == `FTSL_OFS_CTRL);
        sel_flags = (paddr == `FTSL_OFS_FLAGS);
        sel_upper = (paddr == `FTSL_OFS_UPPER);
        sel_lower = (paddr == `FTSL_OFS_LOWER);
        mapped = sel_ctrl | sel_flags | sel_upper | sel_lower;
    end

    // ======================================================================
    // Read views
    always_comb begin
        rd_ctrl = 32'h0000_0000;
        rd_ctrl[`FTSL_CTRL_TOGGLE_IE] = q.toggle_ie;
        rd_ctrl[`FTSL_CTRL_READY_IE] = q.ready_ie;
        rd_ctrl[`FTSL_CTRL_EDGES_HI:`FTSL_CTRL_EDGES_LO] = q.edge_sel;
        rd_ctrl[`FTSL_CTRL_MODE] = q.mode;
        rd_ctrl[`FTSL_CTRL_OOR_IE] = q.oor_ie;
        rd_flags = 32'h0000_0000;
        rd_flags[`FTSL_FLAG_READY] = q.ready_flag;
        rd_flags[`FTSL_FLAG_TOGGLE] = q.toggle_flag;
        rd_flags[`FTSL_FLAG_LEVEL] = q.level;
        rd_flags[`FTSL_FLAG_OOR] = q.out_of_range_flag;
        rd_upper = {16'h0000, q.upper};
        rd_lower = {16'h0000, q.lower};
        if (sel_ctrl) begin
            rd_mux = rd_ctrl;
        end else if (sel_flags) begin
            rd_mux = rd_flags;
        end else if (sel_upper) begin
            rd_mux = rd_upper;
        end else if (sel_lower) begin
            rd_mux = rd_lower;
        end else begin
            rd_mux = 32'h0000_0000;
        end
    end

    // ======================================================================
    // Bus strobes
    always_comb begin
        access = psel & penable;
        // A write lands only on the edge that also samples pready high.
        commit = access & (q.bus_st == FTSL_BUS_RESP);
        wr = commit & pwrite & mapped;
        clr_ready = wr & sel_flags & pwdata[`FTSL_FLAG_READY];
        clr_toggle = wr & sel_flags & pwdata[`FTSL_FLAG_TOGGLE];
        clr_oor = wr & sel_flags & pwdata[`FTSL_FLAG_OOR];
    end

    // ======================================================================
    // Event detection
    always_comb begin
        above = (period_count > q.upper);
        // A zero lower bound can never be undercut, so it disables the check.
        below = (period_count < q.lower);
        set_ready = q.mode & latch_pulse;
        set_toggle = q.level ^ q.level_prev;
        set_oor = above | below;
    end

    // ======================================================================
    // Next state
    always_comb begin
        d = q;

        // Input sampling.
        d.level = tach_in;
        d.level_prev = q.level;

        // Bus response.
        unique case (q.bus_st)
            FTSL_BUS_IDLE: begin
                d.pready = 1'b0;
                d.pslverr = 1'b0;
                if (access) begin
                    d.bus_st = FTSL_BUS_RESP;
                    d.pready = 1'b1;
                    d.pslverr = ~mapped;
                    d.prdata = pwrite ? 32'h0000_0000 : rd_mux;
                end
            end
            FTSL_BUS_RESP: begin
                d.bus_st = FTSL_BUS_IDLE;
                d.pready = 1'b0;
                d.pslverr = 1'b0;
            end
        endcase

        // Control register.
        if (wr && sel_ctrl) begin
            d.toggle_ie = pwdata[`FTSL_CTRL_TOGGLE_IE];
            d.ready_ie = pwdata[`FTSL_CTRL_READY_IE];
            d.edge_sel = pwdata[`FTSL_CTRL_EDGES_HI:`FTSL_CTRL_EDGES_LO];
            d.mode = pwdata[`FTSL_CTRL_MODE];
            d.oor_ie = pwdata[`FTSL_CTRL_OOR_IE];
        end

        // Bounds.
        if (wr && sel_upper) begin
            d.upper = pwdata[15:0];
        end
        if (wr && sel_lower) begin
            d.lower = pwdata[15:0];
        end

        // Count-ready flag: a set outranks a clear in the same cycle.
        if (!q.mode) begin
            d.ready_flag = 1'b0;
        end else if (set_ready) begin
            d.ready_flag = 1'b1;
        end else if (clr_ready) begin
            d.ready_flag = 1'b0;
        end

        // Toggle flag.
        if (set_toggle) begin
            d.toggle_flag = 1'b1;
        end else if (clr_toggle) begin
            d.toggle_flag = 1'b0;
        end

        // Out-of-range flag.
        if (set_oor) begin
            d.out_of_range_flag = 1'b1;
        end else if (clr_oor) begin
            d.out_of_range_flag = 1'b0;
        end

        // Interrupt request is registered from the next flag values, so it rises with the flag.
        // An enable change reaches it one cycle after the control write lands.
        d.irq = (d.ready_flag & q.ready_ie)
            | (d.toggle_flag & q.toggle_ie)
            | (d.out_of_range_flag & q.oor_ie);
    end

    // ======================================================================
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.upper <= `FTSL_UPPER_RST;
            q.lower <= `FTSL_LOWER_RST;
        end else begin
            q <= d;
        end
    end

    // ======================================================================
    // Outputs
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign irq = q.irq;

endmodule

//--- testbench/ftsl_fan_model.sv
// Fan model: a square wave with a half period counted in pclk cycles.
// Assumes the bench controls run and the half period on pclk.
module ftsl_fan_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic run,
    input wire logic [7:0] half_cycles,
    // Fan output
    output logic tach
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] cnt_q;
    // ======================================================================
    // Wave
    // A stopped rotor holds its level, as a locked-rotor output would.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 8'h00;
            tach <= 1'b0;
        end else if (run && cnt_q >= half_cycles) begin
            cnt_q <= 8'h00;
            tach <= ~tach;
        end else if (run) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule

//--- testbench/ftsl_top_properties.sv
// Assertions on the ports of the tachometer status block.
// Assumes one pclk domain with presetn as async active-low reset.
module ftsl_top_properties #(
    parameter int REF_DIV = 2500
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Fan and interrupt
    input wire logic tach_in,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 100ps;
    // ======================================================================
    // Properties
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    answer_time_a: assert property (psel && penable && !$past(penable) |=> pready)
        else $error("pready late");
    ready_in_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
    err_decode_a: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}))
        else $error("pslverr wrong for address");
    write_zero_a: assert property (pready && pwrite |-> prdata == 32'h0) else $error("prdata on write");
    flags_reserved_a: assert property (pready && !pwrite && paddr == 8'h04 |-> prdata[31:4] == 28'h0)
        else $error("reserved flag bits set");
    bound_width_a: assert property (pready && !pwrite && paddr inside {8'h08, 8'h0C} |-> prdata[31:16] == 16'h0)
        else $error("bound wider than 16 bits");
    level_bit_a: assert property (pready && !pwrite && paddr == 8'h04 && $stable(tach_in) &&
        $past(tach_in, 2) == tach_in && $past(tach_in, 3) == tach_in |-> prdata[1] == tach_in)
        else $error("level bit differs from input");
    irq_off_a: assert property (pready && pwrite && paddr == 8'h00 && pwdata[15] == 1'b0 &&
        pwdata[14] == 1'b0 && pwdata[0] == 1'b0 |=> ##1 !irq) else $error("irq with all enables off");
endmodule

bind ftsl_top ftsl_top_properties #(.REF_DIV(REF_DIV)) i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tach_in(tach_in), .irq(irq));

//--- testbench/ftsl_top_test.sv
// Self-checking bench of the tachometer status block.
// Assumes the APB slave and a fan model; REF_DIV is cut to 4.
`include "ftsl_map.svh"

module ftsl_top_test import ftsl_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic tach_in;
    logic irq;
    logic run = 1'b0;
    logic [31:0] rd;
    logic err;
    int n_fail = 0;
    int checks = 0;

    always #2 pclk = ~pclk;

    ftsl_top #(.REF_DIV(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tach_in(tach_in), .irq(irq));
    ftsl_fan_model i_fan (.pclk(pclk), .presetn(presetn), .run(run), .half_cycles(8'h14), .tach(tach_in));

    // ======================================================================
    // Tasks
    task automatic final_report();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // The request is held until pready is seen high, then released.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk("pready", {31'h0, pready}, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(name, rd, exp);
    endtask

    // One extra edge lets a just-written enable reach the registered request.
    task automatic irq_chk(input logic exp);
        @(posedge pclk);
        @(negedge pclk);
        chk("irq", {31'h0, irq}, {31'h0, exp});
    endtask

    // Runs the fan until the input reaches v, then stalls it there.
    task automatic fan_stop_at(input logic v);
        int n;
        n = 0;
        run <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (tach_in !== v && n < 500);
        chk("fan", {31'h0, tach_in}, {31'h0, v});
        run <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask

    // ======================================================================
    // Tests
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("ctrl", `FTSL_OFS_CTRL, 32'h0);
        rd_chk("flags", `FTSL_OFS_FLAGS, 32'h0);
        rd_chk("upper", `FTSL_OFS_UPPER, 32'h0000FFFF);
        rd_chk("lower", `FTSL_OFS_LOWER, 32'h0);
        rd_chk("unmapped", 8'h10, 32'h0);
        chk("slverr", {31'h0, err}, 32'h1);
        xfer(1'b1, `FTSL_OFS_UPPER, 32'h1234ABCD);
        rd_chk("upper", `FTSL_OFS_UPPER, 32'h0000ABCD);
        fan_stop_at(1'b1);
        xfer(1'b1, `FTSL_OFS_CTRL, 32'h8000);
        xfer(1'b1, `FTSL_OFS_FLAGS, 32'hF);
        rd_chk("flags", `FTSL_OFS_FLAGS, 32'h2);
        repeat (20) @(posedge pclk);
        irq_chk(1'b0);
        fan_stop_at(1'b0);
        irq_chk(1'b1);
        xfer(1'b1, `FTSL_OFS_FLAGS, 32'h0);
        rd_chk("flags", `FTSL_OFS_FLAGS, 32'h4);
        xfer(1'b1, `FTSL_OFS_FLAGS, 32'h4);
        rd_chk("flags", `FTSL_OFS_FLAGS, 32'h0);
        irq_chk(1'b0);
        xfer(1'b1, `FTSL_OFS_CTRL, 32'h1);
        xfer(1'b1, `FTSL_OFS_LOWER, 32'h7FFF);
        xfer(1'b1, `FTSL_OFS_FLAGS, 32'h1);
        rd_chk("flags", `FTSL_OFS_FLAGS, 32'h1);
        irq_chk(1'b1);
        xfer(1'b1, `FTSL_OFS_LOWER, 32'h0);
        xfer(1'b1, `FTSL_OFS_FLAGS, 32'h1);
        rd_chk("flags", `FTSL_OFS_FLAGS, 32'h0);
        xfer(1'b1, `FTSL_OFS_UPPER, 32'h1);
        rd_chk("flags", `FTSL_OFS_FLAGS, 32'h0);
        xfer(1'b1, `FTSL_OFS_UPPER, 32'h0);
        rd_chk("flags", `FTSL_OFS_FLAGS, 32'h1);
        xfer(1'b1, `FTSL_OFS_UPPER, 32'hFFFF);
        xfer(1'b1, `FTSL_OFS_FLAGS, 32'h1);
        rd_chk("flags", `FTSL_OFS_FLAGS, 32'h0);
        xfer(1'b1, `FTSL_OFS_CTRL, 32'h4400);
        fan_stop_at(1'b1);
        fan_stop_at(1'b0);
        repeat (4) @(posedge pclk);
        irq_chk(1'b1);
        xfer(1'b1, `FTSL_OFS_FLAGS, 32'h0);
        rd_chk("flags", `FTSL_OFS_FLAGS, 32'hC);
        xfer(1'b1, `FTSL_OFS_FLAGS, 32'h8);
        rd_chk("flags", `FTSL_OFS_FLAGS, 32'h4);
        xfer(1'b1, `FTSL_OFS_CTRL, 32'h4C00);
        rd_chk("ctrl", `FTSL_OFS_CTRL, 32'h4C00);
        fan_stop_at(1'b1);
        rd_chk("flags", `FTSL_OFS_FLAGS, 32'h6);
        fan_stop_at(1'b0);
        rd_chk("flags", `FTSL_OFS_FLAGS, 32'hC);
        xfer(1'b1, `FTSL_OFS_CTRL, 32'hFFFFFFFF);
        rd_chk("ctrl", `FTSL_OFS_CTRL, 32'h0000DC01);
        irq_chk(1'b1);
        xfer(1'b1, `FTSL_OFS_CTRL, 32'h0);
        irq_chk(1'b0);
        final_report();
    end

    // Cuts a hang short; the tests need about 350 cycles.
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        final_report();
    end
endmodule
